// [common/tmcp_consts.svh]
`ifndef TMCP_CONSTS_SVH
`define TMCP_CONSTS_SVH

// register byte offsets
`define TMCP_OFF_TMR_CTRL 8'h00
`define TMCP_OFF_COUNT 8'h04
`define TMCP_OFF_MATCH_ACT 8'h14
`define TMCP_OFF_MATCH_0 8'h18
`define TMCP_OFF_MATCH_1 8'h1c
`define TMCP_OFF_MATCH_2 8'h20
`define TMCP_OFF_MATCH_3 8'h24
`define TMCP_OFF_CAP_SETUP 8'h28
`define TMCP_OFF_CAP_COUNT 8'h2c
`define TMCP_OFF_PIN_ACT 8'h30
`define TMCP_OFF_PULSE 8'h34
`define TMCP_OFF_RAW_FLAGS 8'h38
`define TMCP_OFF_FLAG_CLR 8'h3c

// reset value shared by every register
`define TMCP_RST_WORD 32'h0000_0000

// timer control fields
`define TMCP_CTRL_RUN 0
`define TMCP_CTRL_CNT_CLR 1

// match action control: three bits per channel
`define TMCP_MACT_IRQ 0
`define TMCP_MACT_RST 1
`define TMCP_MACT_HALT 2
`define TMCP_MACT_STRIDE 3
`define TMCP_MACT_WIDTH 12

// capture setup fields
`define TMCP_CAP_RISE 0
`define TMCP_CAP_FALL 1
`define TMCP_CAP_IRQ 2
`define TMCP_CAP_EN 3
`define TMCP_CAP_WIDTH 4

// pin action setup fields
`define TMCP_PIN_STATE_LSB 0
`define TMCP_PIN_SEL_LSB 4
`define TMCP_PIN_WIDTH 12

// pulse output setup fields
`define TMCP_PULSE_MODE_LSB 0
`define TMCP_PULSE_OWNER_LSB 20
`define TMCP_PULSE_OWNER_MSB 23

// raw flag fields
`define TMCP_RAW_CAP 4
`define TMCP_RAW_WIDTH 5

`endif

// [common/tmcp_pkg.sv]
package tmcp_pkg;

	typedef enum logic [1:0] {
		TMCP_ACT_HOLD = 2'h0,
		TMCP_ACT_LOW = 2'h1,
		TMCP_ACT_HIGH = 2'h2,
		TMCP_ACT_TOGGLE = 2'h3
	} tmcp_pin_act_t;

	typedef logic [31:0] tmcp_word_t;

endpackage

// [logic/tmcp_edge_sync.sv]
module tmcp_edge_sync (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic pinIn,
	output logic riseSeen,
	output logic fallSeen
);

	logic meta_reg;
	logic stable_reg;
	logic last_reg;

	// meta_reg feeds only stable_reg; edges come from two settled samples
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_reg <= 1'b0;
			stable_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= pinIn;
			stable_reg <= meta_reg;
			last_reg <= stable_reg;
		end
	end

	assign riseSeen = stable_reg & ~last_reg;
	assign fallSeen = ~stable_reg & last_reg;

endmodule

// [logic/tmcp_top.sv]
`include "tmcp_consts.svh"

module tmcp_top (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [31:0] regRdData,
	input wire logic capture_input_pin,
	output logic captureRoleSel,
	output logic [3:0] match_out,
	output logic [3:0] matchOutEn,
	output logic countRunning,
	output logic irqReq
);

	localparam int NCH = 4;

	// register state
	logic count_run_reg;
	logic count_run_next;
	logic cntClr_reg;
	logic cntClr_next;
	tmcp_pkg::tmcp_word_t timer_count_reg;
	tmcp_pkg::tmcp_word_t timer_count_next;
	logic [`TMCP_MACT_WIDTH-1:0] match_action_control_reg;
	tmcp_pkg::tmcp_word_t match_value_reg [NCH];
	logic [`TMCP_CAP_WIDTH-1:0] capture_setup_reg;
	tmcp_pkg::tmcp_word_t captured_count_reg;
	logic [NCH-1:0] pin_state_reg;
	logic [NCH-1:0] pin_state_next;
	logic [2*NCH-1:0] pin_action_sel_reg;
	logic [NCH-1:0] pulse_mode_sel_reg;
	logic [NCH-1:0] pin_owner_sel_reg;
	logic [`TMCP_RAW_WIDTH-1:0] rawFlags_reg;
	logic [`TMCP_RAW_WIDTH-1:0] rawFlags_next;
	logic [NCH-1:0] eqPrev_reg;
	logic [31:0] rdData_reg;
	logic [31:0] rdData_next;
	logic captureRole_reg;
	logic [3:0] matchOut_reg;
	logic [3:0] matchOutEn_reg;
	logic irq_reg;
	logic irq_next;

	// decoded strobes
	logic wrCtrl;
	logic wrCount;
	logic wrMatchAct;
	logic wrCapSetup;
	logic wrPinAct;
	logic wrPulse;
	logic wrFlagClr;
	logic [NCH-1:0] wrMatch;

	// event wires
	logic [NCH-1:0] eqNow;
	logic [NCH-1:0] matchEvt;
	logic [NCH-1:0] rstReq;
	logic [NCH-1:0] haltReq;
	logic anyRst;
	logic anyHalt;
	logic capRise;
	logic capFall;
	logic captureEvt;
	logic [`TMCP_RAW_WIDTH-1:0] rawSet;
	logic [`TMCP_RAW_WIDTH-1:0] rawClr;
	logic [`TMCP_RAW_WIDTH-1:0] flagEnables;

	function automatic logic wrHit(input logic [7:0] addr, input logic [7:0] off,
			input logic stb);
		wrHit = stb & (addr == off);
	endfunction

	function automatic logic pinAction(input tmcp_pkg::tmcp_pin_act_t act,
			input logic cur);
		case (act)
			tmcp_pkg::TMCP_ACT_LOW: pinAction = 1'b0;
			tmcp_pkg::TMCP_ACT_HIGH: pinAction = 1'b1;
			tmcp_pkg::TMCP_ACT_TOGGLE: pinAction = ~cur;
			default: pinAction = cur;
		endcase
	endfunction

	assign wrCtrl = wrHit(regAddr, `TMCP_OFF_TMR_CTRL, regWrStb);
	assign wrCount = wrHit(regAddr, `TMCP_OFF_COUNT, regWrStb);
	assign wrMatchAct = wrHit(regAddr, `TMCP_OFF_MATCH_ACT, regWrStb);
	assign wrCapSetup = wrHit(regAddr, `TMCP_OFF_CAP_SETUP, regWrStb);
	assign wrPinAct = wrHit(regAddr, `TMCP_OFF_PIN_ACT, regWrStb);
	assign wrPulse = wrHit(regAddr, `TMCP_OFF_PULSE, regWrStb);
	assign wrFlagClr = wrHit(regAddr, `TMCP_OFF_FLAG_CLR, regWrStb);
	assign wrMatch[0] = wrHit(regAddr, `TMCP_OFF_MATCH_0, regWrStb);
	assign wrMatch[1] = wrHit(regAddr, `TMCP_OFF_MATCH_1, regWrStb);
	assign wrMatch[2] = wrHit(regAddr, `TMCP_OFF_MATCH_2, regWrStb);
	assign wrMatch[3] = wrHit(regAddr, `TMCP_OFF_MATCH_3, regWrStb);

	// per-channel compare, action decode and pin state
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			localparam int AB = gi * `TMCP_MACT_STRIDE;
			tmcp_pkg::tmcp_pin_act_t actSel;

			assign eqNow[gi] = (timer_count_reg == match_value_reg[gi]);
			// a held count would otherwise re-fire every cycle
			assign matchEvt[gi] = eqNow[gi] & ~eqPrev_reg[gi];
			assign rstReq[gi] = matchEvt[gi] &
				match_action_control_reg[AB + `TMCP_MACT_RST];
			assign haltReq[gi] = matchEvt[gi] &
				match_action_control_reg[AB + `TMCP_MACT_HALT];
			assign actSel = tmcp_pkg::tmcp_pin_act_t'(pin_action_sel_reg[2*gi +: 2]);

			always_comb begin
				if (pulse_mode_sel_reg[gi]) begin
					if (anyRst)
						// zero match sets in the same step as the clear
						pin_state_next[gi] = (match_value_reg[gi] == 32'h0000_0000);
					else if (matchEvt[gi])
						pin_state_next[gi] = 1'b1;
					else if (wrPinAct)
						pin_state_next[gi] = regWrData[`TMCP_PIN_STATE_LSB + gi];
					else
						pin_state_next[gi] = pin_state_reg[gi];
				end else begin
					if (matchEvt[gi])
						pin_state_next[gi] = pinAction(actSel, pin_state_reg[gi]);
					else if (wrPinAct)
						pin_state_next[gi] = regWrData[`TMCP_PIN_STATE_LSB + gi];
					else
						pin_state_next[gi] = pin_state_reg[gi];
				end
			end

			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					match_value_reg[gi] <= `TMCP_RST_WORD;
					eqPrev_reg[gi] <= 1'b0;
				end else begin
					eqPrev_reg[gi] <= eqNow[gi];
					if (wrMatch[gi])
						match_value_reg[gi] <= regWrData;
				end
			end
		end
	endgenerate

	assign anyRst = |rstReq;
	assign anyHalt = |haltReq;

	// capture path
	tmcp_edge_sync u_cap_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.pinIn(capture_input_pin),
		.riseSeen(capRise),
		.fallSeen(capFall)
	);

	assign captureEvt = capture_setup_reg[`TMCP_CAP_EN] &
		((capRise & capture_setup_reg[`TMCP_CAP_RISE]) |
		(capFall & capture_setup_reg[`TMCP_CAP_FALL]));

	// timer count: reset beats halt beats increment; a halt leaves the count
	always_comb begin
		timer_count_next = timer_count_reg;
		if (anyRst | cntClr_reg)
			timer_count_next = `TMCP_RST_WORD;
		else if (wrCount)
			timer_count_next = regWrData;
		else if (count_run_reg & ~anyHalt)
			timer_count_next = timer_count_reg + 32'h0000_0001;
	end

	always_comb begin
		count_run_next = count_run_reg;
		if (anyHalt)
			count_run_next = 1'b0;
		else if (wrCtrl)
			count_run_next = regWrData[`TMCP_CTRL_RUN];
	end

	// counter clear self-cleans after one clock
	assign cntClr_next = wrCtrl & regWrData[`TMCP_CTRL_CNT_CLR];

	// raw flags: hardware set wins over a clear in the same cycle
	assign rawSet = {captureEvt, matchEvt};
	assign rawClr = wrFlagClr ? regWrData[`TMCP_RAW_WIDTH-1:0] : 5'h00;
	assign rawFlags_next = rawSet | (rawFlags_reg & ~rawClr);

	assign flagEnables = {capture_setup_reg[`TMCP_CAP_IRQ],
		match_action_control_reg[9], match_action_control_reg[6],
		match_action_control_reg[3], match_action_control_reg[0]};
	assign irq_next = |(rawFlags_next & flagEnables);

	// read mux; unmapped offsets answer zero
	always_comb begin
		rdData_next = 32'h0000_0000;
		if (regRdStb) begin
			case (regAddr)
				`TMCP_OFF_TMR_CTRL: rdData_next = {31'h0000_0000, count_run_reg};
				`TMCP_OFF_COUNT: rdData_next = timer_count_reg;
				`TMCP_OFF_MATCH_ACT: rdData_next = {20'h0_0000, match_action_control_reg};
				`TMCP_OFF_MATCH_0: rdData_next = match_value_reg[0];
				`TMCP_OFF_MATCH_1: rdData_next = match_value_reg[1];
				`TMCP_OFF_MATCH_2: rdData_next = match_value_reg[2];
				`TMCP_OFF_MATCH_3: rdData_next = match_value_reg[3];
				`TMCP_OFF_CAP_SETUP: rdData_next = {28'h000_0000, capture_setup_reg};
				`TMCP_OFF_CAP_COUNT: rdData_next = captured_count_reg;
				`TMCP_OFF_PIN_ACT: rdData_next = {20'h0_0000, pin_action_sel_reg,
					pin_state_reg};
				`TMCP_OFF_PULSE: rdData_next = {8'h00, pin_owner_sel_reg, 16'h0000,
					pulse_mode_sel_reg};
				`TMCP_OFF_RAW_FLAGS: rdData_next = {27'h000_0000, rawFlags_reg};
				default: rdData_next = 32'h0000_0000;
			endcase
		end
	end

	// configuration registers, one short flop group per register
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			match_action_control_reg <= 12'h000;
		else if (wrMatchAct)
			match_action_control_reg <= regWrData[`TMCP_MACT_WIDTH-1:0];
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			capture_setup_reg <= 4'h0;
		else if (wrCapSetup)
			capture_setup_reg <= regWrData[`TMCP_CAP_WIDTH-1:0];
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			pin_action_sel_reg <= 8'h00;
		else if (wrPinAct)
			pin_action_sel_reg <= regWrData[`TMCP_PIN_WIDTH-1:`TMCP_PIN_SEL_LSB];
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pulse_mode_sel_reg <= 4'h0;
			pin_owner_sel_reg <= 4'h0;
		end else if (wrPulse) begin
			pulse_mode_sel_reg <= regWrData[`TMCP_PULSE_MODE_LSB +: 4];
			pin_owner_sel_reg <=
				regWrData[`TMCP_PULSE_OWNER_MSB:`TMCP_PULSE_OWNER_LSB];
		end
	end

	// timer count and run bit
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			count_run_reg <= 1'b0;
			cntClr_reg <= 1'b0;
			timer_count_reg <= `TMCP_RST_WORD;
		end else begin
			count_run_reg <= count_run_next;
			cntClr_reg <= cntClr_next;
			timer_count_reg <= timer_count_next;
		end
	end

	// pin state and raw flags
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin_state_reg <= 4'h0;
			rawFlags_reg <= 5'h00;
		end else begin
			pin_state_reg <= pin_state_next;
			rawFlags_reg <= rawFlags_next;
		end
	end

	// captured count moves only on a qualifying edge
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			captured_count_reg <= `TMCP_RST_WORD;
		else if (captureEvt)
			captured_count_reg <= timer_count_reg;
	end

	// read data stands one cycle, then falls back to zero
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			rdData_reg <= 32'h0000_0000;
		else
			rdData_reg <= rdData_next;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			irq_reg <= 1'b0;
		else
			irq_reg <= irq_next;
	end

	// pin-facing flops; role and owner trail their register bits by one clock
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			captureRole_reg <= 1'b0;
			matchOut_reg <= 4'h0;
			matchOutEn_reg <= 4'h0;
		end else begin
			captureRole_reg <= capture_setup_reg[`TMCP_CAP_EN];
			matchOut_reg <= pin_state_next;
			matchOutEn_reg <= pin_owner_sel_reg;
		end
	end

	assign regRdData = rdData_reg;
	assign captureRoleSel = captureRole_reg;
	assign match_out = matchOut_reg;
	assign matchOutEn = matchOutEn_reg;
	assign countRunning = count_run_reg;
	assign irqReq = irq_reg;

endmodule

// [tb/tmcp_top_chk.sv]
module tmcp_top_chk (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic [31:0] regRdData,
	input wire logic capture_input_pin,
	input wire logic captureRoleSel,
	input wire logic [3:0] match_out,
	input wire logic [3:0] matchOutEn,
	input wire logic countRunning,
	input wire logic irqReq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] mactReg;
	logic capIrqReg;
	wire logic capWr = regWrStb && regAddr == 8'h28;
	wire logic ownWr = regWrStb && regAddr == 8'h34;
	wire logic ctrlWr = regWrStb && regAddr == 8'h00;
	wire logic ctrlOffWr = ctrlWr && !regWrData[0];
	wire logic runBit = regWrData[0];
	wire logic capEnBit = regWrData[3];
	wire logic [3:0] ownBits = regWrData[23:20];
	wire logic haltArmed = mactReg[2] | mactReg[5] | mactReg[8] | mactReg[11];
	wire logic irqOff = !(mactReg[0] | mactReg[3] | mactReg[6] | mactReg[9] | capIrqReg);
	// shadow of the enables, so irq and halt causes can be judged
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mactReg <= 12'h000;
			capIrqReg <= 1'b0;
		end else begin
			if (regWrStb && regAddr == 8'h14) mactReg <= regWrData[11:0];
			if (capWr) capIrqReg <= regWrData[2];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence wrMatch;
		regWrStb && regAddr inside {8'h18, 8'h1c, 8'h20, 8'h24};
	endsequence
	sequence rdSame;
		regRdStb && !regWrStb && regAddr == $past(regAddr);
	endsequence
	chk_match_readback: assert property (wrMatch ##1 rdSame |=> regRdData == $past(regWrData, 2))
		else $error("match value readback wrong");
	chk_rd_quiet: assert property (!regRdStb |=> regRdData == 32'h0)
		else $error("read data not zero");
	// role and owner pins trail the register write by two clocks
	chk_role_follow: assert property (capWr |=> ##1 captureRoleSel == $past(capEnBit, 2))
		else $error("capture role wrong");
	chk_role_hold: assert property (!capWr |=> ##1 $stable(captureRoleSel))
		else $error("capture role moved");
	chk_owner_follow: assert property (ownWr |=> ##1 matchOutEn == $past(ownBits, 2))
		else $error("pin owner wrong");
	chk_owner_hold: assert property (!ownWr |=> ##1 $stable(matchOutEn))
		else $error("pin owner moved");
	chk_halt_cause: assert property ($fell(countRunning) |-> haltArmed || $past(ctrlOffWr))
		else $error("run bit dropped without cause");
	chk_run_write: assert property (ctrlWr && !haltArmed |=> countRunning == $past(runBit))
		else $error("run bit write lost");
	chk_irq_masked: assert property (irqOff |=> !irqReq)
		else $error("request with enables off");
endmodule

bind tmcp_top tmcp_top_chk chk_u (.ref_clk, .sys_rst, .regAddr, .regWrData, .regWrStb,
	.regRdStb, .regRdData, .capture_input_pin, .captureRoleSel, .match_out, .matchOutEn,
	.countRunning, .irqReq);

// [tb/tmcp_pin_model.sv]
module tmcp_pin_model (
	input wire logic reqLvl,
	input wire logic slowEdge,
	output logic pinLvl
);
	timeunit 1ns;
	timeprecision 1ns;
	// pin moves mid-cycle, unrelated to the clock edge
	initial pinLvl = 1'b0;
	always @(reqLvl) begin
		if (slowEdge) pinLvl <= #113 reqLvl;
		else pinLvl <= #13 reqLvl;
	end
endmodule

// [tb/test_timer_match_capture_pwm.sv]
module test_timer_match_capture_pwm;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, sys_rst, regWrStb, regRdStb, reqLvl, pinLvl, slowEdge;
	logic rdLag = 1'b0;
	logic [7:0] regAddr;
	logic [31:0] regWrData, regRdData, prevCap, rnd;
	logic captureRoleSel, countRunning, irqReq;
	logic [3:0] match_out, matchOutEn;
	logic [31:0] expQ[$];
	logic [3:0] capSet[6] = '{4'hd, 4'h9, 4'h3, 4'hb, 4'hb, 4'ha};
	logic pinSeq[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	logic capHit[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	int error_cnt = 0;
	int n_checks = 0;
	int hi1, hi2;
	tmcp_top dut_u (.ref_clk, .sys_rst, .regAddr, .regWrData, .regWrStb, .regRdStb,
		.regRdData, .capture_input_pin(pinLvl), .captureRoleSel, .match_out, .matchOutEn,
		.countRunning, .irqReq);
	tmcp_pin_model pin_u (.reqLvl, .slowEdge, .pinLvl);
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// wr and rd each raise their own strobe and lower the other, so back-to-back calls need no idle between them
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		regRdStb <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		regAddr <= a;
		regRdStb <= 1'b1;
		regWrStb <= 1'b0;
		expQ.push_back(e);
		@(posedge ref_clk);
	endtask
	task automatic idle(input int n);
		regWrStb <= 1'b0;
		regRdStb <= 1'b0;
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic rst();
		sys_rst <= 1'b1;
		idle(2);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
	endtask
	always @(posedge ref_clk) rdLag <= regRdStb;
	always @(negedge ref_clk) begin
		if (rdLag && expQ.size() == 0) chk("read queue", 32'h0, 32'h1);
		else if (rdLag) chk("read data", expQ.pop_front(), regRdData);
	end
	initial begin
		sys_rst = 1'b1;
		regWrStb = 1'b0;
		regRdStb = 1'b0;
		regAddr = 8'h00;
		regWrData = 32'h0;
		reqLvl = 1'b0;
		slowEdge = 1'b0;
		void'($urandom(12));
		rst();
		for (int i = 0; i < 8; i++) rd(8'h18 + 8'(4 * i), 32'h0);
		rd(8'h40, 32'h0);
		for (int i = 0; i < 4; i++) begin
			rnd = $urandom;
			wr(8'h18 + 8'(4 * i), rnd);
			rd(8'h18 + 8'(4 * i), rnd);
		end
		wr(8'h2c, 32'hffff_ffff);
		rd(8'h2c, 32'h0);
		for (int i = 0; i < 4; i++) wr(8'h18 + 8'(4 * i), 32'(5 + i));
		wr(8'h34, 32'h00f0_0000);
		wr(8'h30, 32'h0000_0399);
		wr(8'h00, 32'h1);
		idle(20);
		wr(8'h00, 32'h0);
		idle(2);
		chk("match pins", 32'he, {28'h0, match_out});
		chk("pin enables", 32'hf, {28'h0, matchOutEn});
		rd(8'h30, 32'h0000_039e);
		wr(8'h04, 32'h7);
		idle(6);
		chk("single toggle", 32'ha, {28'h0, match_out});
		rst();
		wr(8'h18, 32'ha);
		wr(8'h1c, 32'h4);
		wr(8'h14, 32'h003);
		wr(8'h34, 32'h00f0_0006);
		wr(8'h00, 32'h1);
		idle(22);
		hi1 = 0;
		hi2 = 0;
		repeat (44) begin
			@(negedge ref_clk);
			hi1 += int'(match_out[1]);
			hi2 += int'(match_out[2]);
		end
		@(posedge ref_clk);
		chk("pulse high cycles", 32'd24, 32'(hi1));
		chk("zero match cycles", 32'd44, 32'(hi2));
		wr(8'h00, 32'h0);
		idle(1);
		rd(8'h38, 32'h0000_000f);
		chk("match request", 32'h1, {31'h0, irqReq});
		wr(8'h3c, 32'h1f);
		idle(2);
		chk("cleared request", 32'h0, {31'h0, irqReq});
		rst();
		wr(8'h24, 32'h3);
		wr(8'h14, 32'h800);
		wr(8'h00, 32'h1);
		idle(1);
		for (int i = 0; i < 40 && countRunning !== 1'b0; i++) @(posedge ref_clk);
		if (countRunning !== 1'b0) begin
			chk("halt wait", 32'h0, 32'h1);
			finish_test();
		end
		rd(8'h04, 32'h3);
		rd(8'h00, 32'h0);
		rst();
		prevCap = 32'h0;
		for (int i = 0; i < 6; i++) begin
			rnd = $urandom;
			slowEdge <= i[0];
			wr(8'h28, {28'h0, capSet[i]});
			wr(8'h04, rnd);
			idle(1);
			reqLvl <= pinSeq[i];
			idle(8);
			chk("capture role", {31'h0, capSet[i][3]}, {31'h0, captureRoleSel});
			if (capHit[i]) prevCap = rnd;
			rd(8'h2c, prevCap);
			if (i == 0) begin
				chk("capture request", 32'h1, {31'h0, irqReq});
				wr(8'h3c, 32'h10);
			end
		end
		idle(4);
		chk("quiet request", 32'h0, {31'h0, irqReq});
		finish_test();
	end
	initial begin
		#2000000;
		chk("run time", 32'h0, 32'h1);
		finish_test();
	end
endmodule
